// ---- usw_peer.sv ----
// usw_peer: behavioural far-side serial device, 8 data bits, 2 stops.
// assumes a bit time of BT clocks and a pulled-up line in the bench.
`timescale 1ns/100ps
module usw_peer #(
   parameter int BT = 16
) (
   input wire logic clk,
   input wire logic rx_i,
   output logic drv_n,
   output logic drv_o,
   output logic [7:0] got,
   output logic got_v,
   output logic got_fe
);
   // ------------------------
   // sender
   // ------------------------
   // stop1 low forces a framing fault on purpose
   task automatic send(input logic [7:0] b, input logic stop1);
      logic [10:0] f;
      // start right after an edge, whatever the caller's phase
      @(posedge clk);
      f = {1'b1, stop1, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         drv_n <= 1'b0;
         drv_o <= f[i];
         repeat (BT) @(posedge clk);
      end
      drv_n <= 1'b1;
   endtask

   // ------------------------
   // receiver, mid-bit sampling
   // ------------------------
   initial begin
      logic [7:0] b;
      logic fe;
      drv_n = 1'b1;
      drv_o = 1'b1;
      got = '0;
      got_v = 1'b0;
      got_fe = 1'b0;
      forever begin
         @(posedge clk);
         got_v <= 1'b0;
         // own frames are not heard back
         if (!rx_i && drv_n) begin
            repeat (BT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
               repeat (BT) @(posedge clk);
               b[i] = rx_i;
            end
            repeat (BT) @(posedge clk);
            fe = !rx_i;
            repeat (BT) @(posedge clk);
            got_fe <= fe | !rx_i;
            got <= b;
            got_v <= 1'b1;
         end
      end
   end
endmodule

// ---- usw_pkg.sv ----
// usw_pkg: register map, field positions, state record and carriers
// for the single-wire serial transceiver; shared by the design and bench.
package usw_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] USW_A_STAT = 8'h00;
   localparam logic [7:0] USW_A_CTL1 = 8'h04;
   localparam logic [7:0] USW_A_CTL2 = 8'h08;
   localparam logic [7:0] USW_A_CTL3 = 8'h0C;
   localparam logic [7:0] USW_A_DATA = 8'h10;
   localparam logic [7:0] USW_A_BAUD_DIVISOR_HIGH = 8'h14;
   localparam logic [7:0] USW_A_BAUD_DIVISOR_LOW = 8'h18;
   localparam logic [7:0] USW_A_FCTL = 8'h1C;
   localparam logic [7:0] USW_A_RX_FIFO_COUNT = 8'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int USW_B_EN = 7;
   localparam int USW_B_PREN = 5;
   localparam int USW_B_PRT = 3;
   localparam int USW_B_TRANSMITTER_ENABLE = 7;
   localparam int USW_B_RECEIVER_ENABLE = 6;
   localparam int USW_B_STOPS = 5;
   localparam int USW_B_RIE = 2;
   localparam int USW_B_SWM = 0;
   localparam int USW_B_TXMIR = 3;
   localparam int USW_B_TRIG = 0;
   // status bits
   localparam int USW_S_PARITY_ERROR_FLAG = 7;
   localparam int USW_S_NF = 6;
   localparam int USW_S_FRAMING_ERROR_FLAG = 5;
   localparam int USW_S_OVERRUN_FLAG = 4;
   localparam int USW_S_RECEIVER_IDLE_FLAG = 3;
   localparam int USW_S_RECEIVE_READY_FLAG = 2;
   localparam int USW_S_TRANSMIT_IDLE_FLAG = 1;
   localparam int USW_S_TRANSMIT_EMPTY_FLAG = 0;
   localparam logic [7:0] USW_STAT_RST = 8'h0B;

   // ----------------------------------------------------------------
   // timing and sizes
   // ----------------------------------------------------------------
   localparam logic [3:0] USW_PH_S0 = 4'h7;
   localparam logic [3:0] USW_PH_S2 = 4'h9;
   localparam logic [3:0] USW_PH_LAST = 4'hF;
   localparam logic [3:0] USW_TX_BITS = 4'hB;
   localparam logic [3:0] USW_RX_LASTBIT = 4'h7;
   localparam int USW_RXF_DEPTH = 4;
   localparam logic [2:0] USW_RXF_FULL = 3'h4;
   localparam logic [1:0] USW_PAR_EVEN = 2'h0;
   localparam logic [1:0] USW_PAR_ODD = 2'h1;
   localparam logic [1:0] USW_PAR_MARK = 2'h2;

   typedef enum logic [3:0] {
      USW_RX_IDLE = 4'h1,
      USW_RX_START = 4'h2,
      USW_RX_DATA = 4'h4,
      USW_RX_STOP = 4'h8
   } usw_rx_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } usw_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } usw_apb_rsp_t;

   typedef struct packed {
      logic en, pren;
      logic [1:0] prt;
      logic transmitter_enable, receiver_enable, stops, receive_irq_enable, single_wire_select, txmir;
      logic [1:0] trig;
      logic [15:0] brd;
      logic parity_error_flag, nf, framing_error_flag, overrun_flag, receiver_idle_flag, receive_ready_flag, transmit_idle_flag, transmit_empty_flag;
      logic [7:0] arm;
      logic [31:0] rdq;
      logic [15:0] bcnt;
      logic s1, s2;
      logic [7:0] tbuf;
      logic tfull, tbusy, txd;
      logic [10:0] tsh;
      logic [3:0] tbits, tph;
      usw_rx_t rst;
      logic [3:0] rph, rbits;
      logic [7:0] rsh;
      logic [2:0] smp;
      logic rnz, rfe;
      logic [USW_RXF_DEPTH-1:0][7:0] mem;
      logic [1:0] wp, rp;
      logic [2:0] cnt;
   } usw_st_t;

   localparam usw_st_t USW_ST_RST = '{rst: USW_RX_IDLE, receiver_idle_flag: 1'h1, transmit_idle_flag: 1'h1,
                                      transmit_empty_flag: 1'h1, txd: 1'h1, default: '0};

endpackage

// ---- usw_uart.sv ----
// usw_uart: single-wire capable serial transceiver with APB registers.
// assumes an APB master on clk and an asynchronous serial partner on the pins.
`timescale 1ns/100ps

module usw_uart (
   input wire logic clk,
   input wire logic rst_n,
   input wire usw_pkg::usw_apb_req_t apb_i,
   output usw_pkg::usw_apb_rsp_t apb_o,
   input wire logic shl_i,
   output logic shl_o,
   output logic shl_oe_n,
   output logic txp_o,
   output logic txp_oe_n,
   output logic rx_irq
);

   usw_pkg::usw_st_t s_q, s_d;
   logic acc, wr, rd, data_wr, data_rd, data_acc, stat_rd;
   logic tick, tx_on, rx_on, push, pe, mj, nz, receive_ready_flag_clr, dis;
   logic [8:0] rmux;
   logic [2:0] lvl;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic par_bit(input logic [6:0] d, input logic [1:0] t);
      logic p;
      p = 1'h0;
      case (t)
         usw_pkg::USW_PAR_EVEN: p = ^d;
         usw_pkg::USW_PAR_ODD: p = ~^d;
         usw_pkg::USW_PAR_MARK: p = 1'h1;
         default: p = 1'h0;
      endcase
      return p;
   endfunction

   // returns {hit, byte}; unmapped addresses miss and read zero
   function automatic logic [8:0] rd_mux(input usw_pkg::usw_st_t s, input logic [7:0] a);
      logic [8:0] r;
      r = 9'h000;
      if (a == usw_pkg::USW_A_STAT) begin
         r = {1'h1, s.parity_error_flag, s.nf, s.framing_error_flag, s.overrun_flag, s.receiver_idle_flag, s.receive_ready_flag, s.transmit_idle_flag, s.transmit_empty_flag};
      end else if (a == usw_pkg::USW_A_CTL1) begin
         r = {1'h1, s.en, 1'h0, s.pren, s.prt, 3'h0};
      end else if (a == usw_pkg::USW_A_CTL2) begin
         r = {1'h1, s.transmitter_enable, s.receiver_enable, s.stops, 2'h0, s.receive_irq_enable, 2'h0};
      end else if (a == usw_pkg::USW_A_CTL3) begin
         r = {1'h1, 4'h0, s.txmir, 2'h0, s.single_wire_select};
      end else if (a == usw_pkg::USW_A_DATA) begin
         r = {1'h1, s.mem[s.rp]};
      end else if (a == usw_pkg::USW_A_BAUD_DIVISOR_HIGH) begin
         r = {1'h1, s.brd[15:8]};
      end else if (a == usw_pkg::USW_A_BAUD_DIVISOR_LOW) begin
         r = {1'h1, s.brd[7:0]};
      end else if (a == usw_pkg::USW_A_FCTL) begin
         r = {1'h1, 6'h00, s.trig};
      end else if (a == usw_pkg::USW_A_RX_FIFO_COUNT) begin
         r = {1'h1, 5'h00, s.cnt};
      end
      return r;
   endfunction

   function automatic logic maj3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      acc = apb_i.psel & apb_i.penable;
      wr = acc & apb_i.pwrite;
      rd = acc & ~apb_i.pwrite;
      data_wr = wr & (apb_i.paddr == usw_pkg::USW_A_DATA);
      data_rd = rd & (apb_i.paddr == usw_pkg::USW_A_DATA);
      data_acc = data_wr | data_rd;
      stat_rd = rd & (apb_i.paddr == usw_pkg::USW_A_STAT);
      rmux = rd_mux(s_q, apb_i.paddr);
      tick = (s_q.bcnt == s_q.brd);
      tx_on = s_q.en & s_q.transmitter_enable & ~(s_q.single_wire_select & s_q.receiver_enable);
      rx_on = s_q.en & s_q.receiver_enable;
      push = 1'h0;
      pe = 1'h0;
      mj = maj3(s_q.smp);
      nz = (s_q.smp != 3'h0) & (s_q.smp != 3'h7);
      receive_ready_flag_clr = 1'h0;
      dis = ~s_q.en;
      lvl = 3'({1'h0, s_q.trig} + 3'h1);
      s_d.s1 = shl_i;
      s_d.s2 = s_q.s1;
      s_d.bcnt = tick ? 16'h0000 : 16'(s_q.bcnt + 16'h0001);

      // read data is captured in the setup cycle so prdata is a flop
      if (apb_i.psel & ~apb_i.penable & ~apb_i.pwrite) begin
         s_d.rdq = {24'h000000, rmux[7:0]};
      end

      if (wr) begin
         if (apb_i.paddr == usw_pkg::USW_A_CTL1) begin
            s_d.en = apb_i.pwdata[usw_pkg::USW_B_EN];
            s_d.pren = apb_i.pwdata[usw_pkg::USW_B_PREN];
            s_d.prt = apb_i.pwdata[usw_pkg::USW_B_PRT+:2];
         end else if (apb_i.paddr == usw_pkg::USW_A_CTL2) begin
            s_d.transmitter_enable = apb_i.pwdata[usw_pkg::USW_B_TRANSMITTER_ENABLE];
            s_d.receiver_enable = apb_i.pwdata[usw_pkg::USW_B_RECEIVER_ENABLE];
            s_d.stops = apb_i.pwdata[usw_pkg::USW_B_STOPS];
            s_d.receive_irq_enable = apb_i.pwdata[usw_pkg::USW_B_RIE];
            if (~s_q.transmitter_enable & apb_i.pwdata[usw_pkg::USW_B_TRANSMITTER_ENABLE]) begin
               s_d.transmit_empty_flag = 1'h1;
            end
         end else if (apb_i.paddr == usw_pkg::USW_A_CTL3) begin
            s_d.single_wire_select = apb_i.pwdata[usw_pkg::USW_B_SWM];
            s_d.txmir = apb_i.pwdata[usw_pkg::USW_B_TXMIR];
         end else if (apb_i.paddr == usw_pkg::USW_A_BAUD_DIVISOR_HIGH) begin
            s_d.brd[15:8] = apb_i.pwdata[7:0];
         end else if (apb_i.paddr == usw_pkg::USW_A_BAUD_DIVISOR_LOW) begin
            s_d.brd[7:0] = apb_i.pwdata[7:0];
         end else if (apb_i.paddr == usw_pkg::USW_A_FCTL) begin
            s_d.trig = apb_i.pwdata[usw_pkg::USW_B_TRIG+:2];
         end else if (apb_i.paddr == usw_pkg::USW_A_DATA) begin
            s_d.tbuf = apb_i.pwdata[7:0];
            s_d.tfull = 1'h1;
         end
      end

      // ----------------------------------------------------------------
      // two-step clears; events below run later so a set wins
      // ----------------------------------------------------------------
      if (stat_rd) begin
         s_d.arm = s_q.rdq[7:0];
      end
      if (data_acc) begin
         if (s_q.arm[usw_pkg::USW_S_PARITY_ERROR_FLAG]) s_d.parity_error_flag = 1'h0;
         if (s_q.arm[usw_pkg::USW_S_NF]) s_d.nf = 1'h0;
         if (s_q.arm[usw_pkg::USW_S_FRAMING_ERROR_FLAG]) s_d.framing_error_flag = 1'h0;
         if (s_q.arm[usw_pkg::USW_S_OVERRUN_FLAG]) s_d.overrun_flag = 1'h0;
         s_d.arm[usw_pkg::USW_S_PARITY_ERROR_FLAG:usw_pkg::USW_S_OVERRUN_FLAG] = 4'h0;
      end
      if (data_rd & (s_q.cnt != 3'h0)) begin
         s_d.rp = 2'(s_q.rp + 2'h1);
         s_d.cnt = 3'(s_q.cnt - 3'h1);
      end
      if (data_rd & s_q.arm[usw_pkg::USW_S_RECEIVE_READY_FLAG]) begin
         s_d.arm[usw_pkg::USW_S_RECEIVE_READY_FLAG] = 1'h0;
         if (s_d.cnt == 3'h0) begin
            receive_ready_flag_clr = 1'h1;
            s_d.receive_ready_flag = 1'h0;
         end
      end
      if (data_wr) begin
         if (s_q.arm[usw_pkg::USW_S_TRANSMIT_EMPTY_FLAG]) s_d.transmit_empty_flag = 1'h0;
         if (s_q.arm[usw_pkg::USW_S_TRANSMIT_IDLE_FLAG]) s_d.transmit_idle_flag = 1'h0;
         s_d.arm[usw_pkg::USW_S_TRANSMIT_IDLE_FLAG] = 1'h0;
         s_d.arm[usw_pkg::USW_S_TRANSMIT_EMPTY_FLAG] = 1'h0;
      end

      // ----------------------------------------------------------------
      // transmitter: start, 8 bits, two stops, 16 ticks per bit
      // ----------------------------------------------------------------
      if (~tx_on) begin
         s_d.tbusy = 1'h0;
         s_d.tph = 4'h0;
         if (~s_q.transmitter_enable) s_d.tfull = 1'h0;
      end else if (~s_q.tbusy & s_q.tfull) begin
         // bit 7 carries parity when parity is on
         s_d.tsh = {2'h3, s_q.pren ? par_bit(s_q.tbuf[6:0], s_q.prt) : s_q.tbuf[7],
                    s_q.tbuf[6:0], 1'h0};
         s_d.tbits = usw_pkg::USW_TX_BITS;
         s_d.tph = 4'h0;
         s_d.tbusy = 1'h1;
         s_d.tfull = 1'h0;
         s_d.transmit_empty_flag = 1'h1;
      end else if (s_q.tbusy & tick) begin
         s_d.tph = 4'(s_q.tph + 4'h1);
         if (s_q.tph == usw_pkg::USW_PH_LAST) begin
            s_d.tsh = {1'h1, s_q.tsh[10:1]};
            s_d.tbits = 4'(s_q.tbits - 4'h1);
            if (s_q.tbits == 4'h1) s_d.tbusy = 1'h0;
         end
      end
      s_d.txd = s_d.tbusy ? s_d.tsh[0] : 1'h1;
      if (s_d.tfull | s_d.tbusy) begin
         s_d.transmit_idle_flag = 1'h0;
      end else if (s_d.transmit_empty_flag) begin
         s_d.transmit_idle_flag = 1'h1;
      end

      // ----------------------------------------------------------------
      // receiver: three mid-bit samples voted, disagreement is noise
      // ----------------------------------------------------------------
      if (~rx_on) begin
         s_d.rst = usw_pkg::USW_RX_IDLE;
      end else begin
         case (s_q.rst)
            usw_pkg::USW_RX_IDLE: begin
               if (~s_q.s2) begin
                  s_d.rst = usw_pkg::USW_RX_START;
                  s_d.rph = 4'h0;
                  s_d.rnz = 1'h0;
                  s_d.rfe = 1'h0;
               end
            end
            default: begin
               if (tick) begin
                  s_d.rph = 4'(s_q.rph + 4'h1);
                  if ((s_q.rph >= usw_pkg::USW_PH_S0) && (s_q.rph <= usw_pkg::USW_PH_S2)) begin
                     s_d.smp = {s_q.smp[1:0], s_q.s2};
                  end
                  if (s_q.rph == usw_pkg::USW_PH_LAST) begin
                     s_d.rnz = s_q.rnz | nz;
                     case (s_q.rst)
                        usw_pkg::USW_RX_START: begin
                           s_d.rst = mj ? usw_pkg::USW_RX_IDLE : usw_pkg::USW_RX_DATA;
                           s_d.rbits = 4'h0;
                        end
                        usw_pkg::USW_RX_DATA: begin
                           s_d.rsh = {mj, s_q.rsh[7:1]};
                           s_d.rbits = 4'(s_q.rbits + 4'h1);
                           if (s_q.rbits == usw_pkg::USW_RX_LASTBIT) begin
                              s_d.rst = usw_pkg::USW_RX_STOP;
                              s_d.rbits = 4'h0;
                           end
                        end
                        default: begin
                           s_d.rfe = s_q.rfe | ~mj;
                           s_d.rbits = 4'(s_q.rbits + 4'h1);
                           if (~s_q.stops | (s_q.rbits != 4'h0)) begin
                              s_d.rst = usw_pkg::USW_RX_IDLE;
                              push = 1'h1;
                           end
                        end
                     endcase
                  end
               end
            end
         endcase
      end
      s_d.receiver_idle_flag = (s_d.rst == usw_pkg::USW_RX_IDLE);

      if (push) begin
         pe = s_q.pren & (s_q.rsh[7] != par_bit(s_q.rsh[6:0], s_q.prt));
         // overrun holds off stores until software clears it
         if (s_d.overrun_flag | (s_d.cnt == usw_pkg::USW_RXF_FULL)) begin
            s_d.overrun_flag = 1'h1;
         end else begin
            s_d.mem[s_q.wp] = s_q.rsh;
            s_d.wp = 2'(s_q.wp + 2'h1);
            s_d.cnt = 3'(s_d.cnt + 3'h1);
            s_d.parity_error_flag = s_d.parity_error_flag | pe;
            s_d.nf = s_d.nf | s_d.rnz;
            s_d.framing_error_flag = s_d.framing_error_flag | s_d.rfe;
            if (s_d.cnt >= lvl) s_d.receive_ready_flag = 1'h1;
         end
      end

      // ----------------------------------------------------------------
      // block disabled: everything back to rest, config kept except transmitter_enable and receiver_enable, which clear
      // ----------------------------------------------------------------
      if (dis) begin
         s_d.wp = 2'h0;
         s_d.rp = 2'h0;
         s_d.cnt = 3'h0;
         s_d.bcnt = 16'h0000;
         s_d.parity_error_flag = 1'h0;
         s_d.nf = 1'h0;
         s_d.framing_error_flag = 1'h0;
         s_d.overrun_flag = 1'h0;
         s_d.receive_ready_flag = 1'h0;
         s_d.receiver_idle_flag = 1'h1;
         s_d.transmit_idle_flag = 1'h1;
         s_d.transmit_empty_flag = 1'h1;
         s_d.transmitter_enable = 1'h0;
         s_d.receiver_enable = 1'h0;
         s_d.tfull = 1'h0;
         s_d.arm = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= usw_pkg::USW_ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle
   assign apb_o.pready = 1'h1;
   assign apb_o.pslverr = acc & ~rmux[8];
   assign apb_o.prdata = s_q.rdq;
   assign shl_o = s_q.txd;
   assign shl_oe_n = ~(s_q.en & s_q.single_wire_select & s_q.transmitter_enable & ~s_q.receiver_enable);
   assign txp_o = s_q.txd;
   assign txp_oe_n = ~(tx_on & (~s_q.single_wire_select | s_q.txmir));
   assign rx_irq = s_q.receive_ready_flag & s_q.receive_irq_enable;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_swm_rx_prio: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.single_wire_select && s_q.receiver_enable |-> shl_oe_n && !(txp_oe_n == 1'h0))
      else $error("shared line driven while receiving");
   a_transmit_empty_flag_on_load: assert property (@(posedge clk) disable iff (!rst_n)
      tx_on && !s_q.tbusy && s_q.tfull |=> s_q.transmit_empty_flag && s_q.tbusy && !s_q.txd)
      else $error("shifter load did not flag empty");
   a_transmit_idle_flag_line_high: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.transmit_idle_flag && tx_on |-> s_q.txd && !s_q.tbusy)
      else $error("idle transmitter not high");
   a_disable_rest: assert property (@(posedge clk) disable iff (!rst_n)
      !s_q.en |=> {s_q.parity_error_flag, s_q.nf, s_q.framing_error_flag, s_q.overrun_flag, s_q.receiver_idle_flag, s_q.receive_ready_flag,
                   s_q.transmit_idle_flag, s_q.transmit_empty_flag} == usw_pkg::USW_STAT_RST && s_q.cnt == 3'h0)
      else $error("disable did not reset status");
   a_ovr_no_store: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.en && s_q.overrun_flag && push && !data_acc |=> s_q.cnt == $past(s_q.cnt))
      else $error("store during overrun");
   a_receive_ready_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(s_q.receive_ready_flag) |-> $past(receive_ready_flag_clr) || $past(dis))
      else $error("ready flag cleared without sequence");
   a_err_with_push: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_q.framing_error_flag) || $rose(s_q.parity_error_flag) || $rose(s_q.nf) |-> $past(push))
      else $error("error flag set outside store");
   a_receiver_idle_flag_busy: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.rst != usw_pkg::USW_RX_IDLE |-> !s_q.receiver_idle_flag ##1 (s_q.receiver_idle_flag || s_q.rst != usw_pkg::USW_RX_IDLE))
      else $error("receiver idle during frame");
   a_tx_abort: assert property (@(posedge clk) disable iff (!rst_n)
      !s_q.transmitter_enable |-> txp_oe_n ##1 (!s_q.tbusy && !s_q.tfull))
      else $error("transmitter not aborted");

endmodule

// ---- usw_uart_bench.sv ----
// usw_uart_bench: self-checking bench for the serial transceiver.
// assumes usw_pkg, usw_uart and usw_peer are compiled before it.
`timescale 1ns/100ps
module usw_uart_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   usw_pkg::usw_apb_req_t req = '0;
   usw_pkg::usw_apb_rsp_t rsp;
   logic shl_o, shl_oe_n, txp_o, txp_oe_n, rx_irq, p_drv_n, p_drv, got_v, got_fe;
   logic single_wire_select = 1'b0;
   logic [7:0] got;
   logic wire_lvl, peer_rx;
   logic [8:0] eq[$];
   logic [7:0] pq[$];
   int mismatches = 0;
   int comparisons = 0;

   always #20 clk = ~clk;
   // shared line has a pull-up when nobody drives it
   assign wire_lvl = !shl_oe_n ? shl_o : (!p_drv_n ? p_drv : 1'b1);
   assign peer_rx = single_wire_select ? wire_lvl : (txp_oe_n ? 1'b1 : txp_o);

   usw_uart dut_u (.clk(clk), .rst_n(rst_n), .apb_i(req), .apb_o(rsp), .shl_i(wire_lvl),
      .shl_o(shl_o), .shl_oe_n(shl_oe_n), .txp_o(txp_o), .txp_oe_n(txp_oe_n),
      .rx_irq(rx_irq));
   usw_peer #(.BT(16)) peer_u (.clk(clk), .rx_i(peer_rx), .drv_n(p_drv_n), .drv_o(p_drv),
      .got(got), .got_v(got_v), .got_fe(got_fe));

   // ------------------------
   // helpers
   // ------------------------
   task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [8:0] exp);
      eq.push_back(exp);
      apb(1'b0, a, 8'h00);
   endtask

   task automatic wait_peer();
      int n;
      n = 0;
      while (pq.size() > 0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      if (pq.size() > 0) begin
         mismatches++;
         end_sim();
      end
      // let the last stop bit finish
      repeat (20) @(posedge clk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   // ------------------------
   // result watcher
   // ------------------------
   always @(posedge clk) begin
      if (req.psel && req.penable && !req.pwrite) begin
         chk("read", {rsp.pslverr, rsp.prdata[7:0]}, eq.pop_front());
      end
      if (got_v) begin
         chk("frame", {got_fe, got}, {1'b0, pq.pop_front()});
      end
      if (single_wire_select && !shl_oe_n && !txp_oe_n) begin
         chk("mirror", {8'h00, txp_o}, {8'h00, shl_o});
      end
   end

   // ------------------------
   // sequence
   // ------------------------
   initial begin
      logic [7:0] b;
      void'($urandom(58781));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      apb(1'b1, usw_pkg::USW_A_STAT, 8'hF4);
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      rd(8'h24, 9'h100);
      tend("reset");
      apb(1'b1, usw_pkg::USW_A_CTL1, 8'h80);
      apb(1'b1, usw_pkg::USW_A_CTL2, 8'h80);
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      for (int i = 0; i < 2; i++) begin
         b = 8'($urandom());
         pq.push_back(b);
         rd(usw_pkg::USW_A_STAT, 9'h00B);
         apb(1'b1, usw_pkg::USW_A_DATA, b);
         rd(usw_pkg::USW_A_STAT, 9'h009);
         wait_peer();
         rd(usw_pkg::USW_A_STAT, 9'h00B);
      end
      chk("txp", {7'h00, txp_oe_n, txp_o}, 9'h001);
      tend("transmit");
      single_wire_select <= 1'b1;
      apb(1'b1, usw_pkg::USW_A_CTL3, 8'h01);
      apb(1'b1, usw_pkg::USW_A_CTL2, 8'hC4);
      // enables land at the access edge; look once they have settled
      @(negedge clk);
      chk("oe both", {7'h00, shl_oe_n, txp_oe_n}, 9'h003);
      b = 8'($urandom());
      fork
         peer_u.send(b, 1'b1);
         begin
            repeat (60) @(posedge clk);
            rd(usw_pkg::USW_A_STAT, 9'h003);
         end
      join
      repeat (4) @(posedge clk);
      chk("irq", {8'h00, rx_irq}, 9'h001);
      rd(usw_pkg::USW_A_STAT, 9'h00F);
      rd(usw_pkg::USW_A_DATA, {1'b0, b});
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      tend("receive");
      // fifth word sets overrun, sixth arrives while it stands
      for (int i = 0; i < 6; i++) begin
         peer_u.send(8'(i), 1'b1);
      end
      rd(usw_pkg::USW_A_RX_FIFO_COUNT, 9'h004);
      rd(usw_pkg::USW_A_STAT, 9'h01F);
      for (int i = 0; i < 4; i++) begin
         rd(usw_pkg::USW_A_DATA, {1'b0, 8'(i)});
      end
      peer_u.send(8'hA5, 1'b1);
      apb(1'b1, usw_pkg::USW_A_CTL1, 8'h00);
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      rd(usw_pkg::USW_A_RX_FIFO_COUNT, 9'h000);
      tend("overrun");
      apb(1'b1, usw_pkg::USW_A_CTL1, 8'hA0);
      apb(1'b1, usw_pkg::USW_A_CTL2, 8'h40);
      b = 8'($urandom());
      b[7] = ~^b[6:0];
      peer_u.send(b, 1'b0);
      repeat (40) @(posedge clk);
      rd(usw_pkg::USW_A_STAT, 9'h0AF);
      rd(usw_pkg::USW_A_DATA, {1'b0, b});
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      tend("errors");
      apb(1'b1, usw_pkg::USW_A_CTL1, 8'h80);
      apb(1'b1, usw_pkg::USW_A_CTL3, 8'h09);
      apb(1'b1, usw_pkg::USW_A_CTL2, 8'h80);
      @(negedge clk);
      chk("oe tx", {7'h00, shl_oe_n, txp_oe_n}, 9'h000);
      b = 8'($urandom());
      pq.push_back(b);
      apb(1'b1, usw_pkg::USW_A_DATA, b);
      wait_peer();
      // abort mid-frame; run ends before the peer finishes the stub
      apb(1'b1, usw_pkg::USW_A_DATA, 8'h3C);
      repeat (50) @(posedge clk);
      apb(1'b1, usw_pkg::USW_A_CTL2, 8'h00);
      @(negedge clk);
      chk("abort", {7'h00, shl_oe_n, txp_oe_n}, 9'h003);
      rd(usw_pkg::USW_A_STAT, 9'h00B);
      tend("single wire");
      end_sim();
   end
endmodule
